// File: rtl/gpio_map.vh
// register offsets, field widths and reset values of the three-port parallel i/o block
`ifndef GPIO_MAP_VH
`define GPIO_MAP_VH
`define PORT_A_DATA_IDX 4'h0
`define PORT_B_DATA_IDX 4'h1
`define PORT_C_DATA_IDX 4'h2
`define PORT_A_DIRECTION_IDX 4'h4
`define PORT_B_DIRECTION_IDX 4'h5
`define PORT_C_DIRECTION_IDX 4'h6
`define PORT_A_PULLUP_ENABLE_IDX 4'hD
`define PORT_C_PULLUP_ENABLE_IDX 4'hE
`define ANALOG_SELECT_IDX 4'h9
`define KEYPAD_IRQ_ENABLE_IDX 4'hA
`define PORT_A_WIDTH 8
`define PORT_B_WIDTH 8
`define PORT_C_WIDTH 7
`define DIRECTION_RESET 8'h00
`define PULLUP_RESET 8'h00
`define ANALOG_SELECT_RESET 8'h00
`define KEYPAD_IRQ_RESET 8'h00
`define ANALOG_SELECT_ENABLE_BIT 3
`define HTRANS_NONSEQ 2'h2
`define HTRANS_SEQ 2'h3
`endif

// File: rtl/three_port_parallel_io.v
// three-port parallel i/o block with ahb-lite register slave
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ns
`include "gpio_map.vh"

module three_port_parallel_io (
  input wire clk, // system clock, 125 MHz
  input wire rst, // asynchronous reset, active high
  input wire hsel, // slave select
  input wire [31:0] haddr, // byte address
  input wire [1:0] htrans, // transfer type
  input wire hwrite, // write when high
  input wire [2:0] hsize, // transfer size
  input wire [31:0] hwdata, // write data
  input wire hready, // bus ready in
  output reg hreadyout, // slave ready
  output reg hresp, // always okay
  output reg [31:0] hrdata, // read data
  input wire [7:0] keypad_inputs, // keypad port pin levels
  output reg [7:0] keypad_out, // keypad port pin drive value
  output reg [7:0] keypad_oe, // keypad port output enable
  output reg [7:0] keypad_pullup, // keypad port pullup on
  output reg [7:0] keypad_irq_pin_en, // keypad pins acting as interrupt inputs
  input wire [7:0] analog_channel_inputs, // analog port pin levels
  output reg [7:0] analog_out, // analog port pin drive value
  output reg [7:0] analog_oe, // analog port output enable
  output reg [7:0] analog_route, // pin switched to the converter
  input wire [6:0] plain_inputs, // plain port pin levels
  output reg [6:0] plain_out, // plain port pin drive value
  output reg [6:0] plain_oe, // plain port output enable
  output reg [6:0] plain_pullup // plain port pullup on
);

  localparam AW = `PORT_A_WIDTH;
  localparam BW = `PORT_B_WIDTH;
  localparam CW = `PORT_C_WIDTH;

  // data latches, no reset; direction, pullup, select and irq registers reset to zero
  reg [AW-1:0] keypad_port_latch;
  reg [BW-1:0] analog_port_latch;
  reg [CW-1:0] plain_port_latch;
  reg [AW-1:0] keypad_port_direction;
  reg [BW-1:0] analog_port_direction;
  reg [CW-1:0] plain_port_direction;
  reg [AW-1:0] keypad_port_pullup_en;
  reg [CW-1:0] plain_port_pullup_en;
  reg [7:0] keypad_irq_enable;
  reg [7:0] analog_select;

  // three-stage pin samplers
  reg [AW-1:0] a_s1, a_s2, a_s3, a_pin;
  reg [BW-1:0] b_s1, b_s2, b_s3, b_pin;
  reg [CW-1:0] c_s1, c_s2, c_s3, c_pin;

  // ahb data phase state
  reg wr_pend;
  reg [3:0] wr_idx;
  wire [3:0] idx = haddr[5:2];
  wire addr_ok = (haddr[31:6] == 26'h0000000) && (haddr[1:0] == 2'h0);
  wire take = hsel && hready && htrans[1];
  wire [2:0] sel_ch = analog_select[2:0];
  wire sel_on = analog_select[`ANALOG_SELECT_ENABLE_BIT];
  reg [BW-1:0] sel_mask;
  reg [31:0] rd_val;

  always @* begin
    sel_mask = {BW{1'b0}};
    if (sel_on) begin
      sel_mask[sel_ch] = 1'b1;
    end
  end

  // pin level changes once the second and third stages agree
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      a_s1 <= {AW{1'b0}};
      a_s2 <= {AW{1'b0}};
      a_s3 <= {AW{1'b0}};
      a_pin <= {AW{1'b0}};
      b_s1 <= {BW{1'b0}};
      b_s2 <= {BW{1'b0}};
      b_s3 <= {BW{1'b0}};
      b_pin <= {BW{1'b0}};
      c_s1 <= {CW{1'b0}};
      c_s2 <= {CW{1'b0}};
      c_s3 <= {CW{1'b0}};
      c_pin <= {CW{1'b0}};
    end else begin
      a_s1 <= keypad_inputs;
      a_s2 <= a_s1;
      a_s3 <= a_s2;
      a_pin <= (a_s2 & a_s3) | (a_pin & (a_s2 ^ a_s3));
      b_s1 <= analog_channel_inputs;
      b_s2 <= b_s1;
      b_s3 <= b_s2;
      b_pin <= (b_s2 & b_s3) | (b_pin & (b_s2 ^ b_s3));
      c_s1 <= plain_inputs;
      c_s2 <= c_s1;
      c_s3 <= c_s2;
      c_pin <= (c_s2 & c_s3) | (c_pin & (c_s2 ^ c_s3));
    end
  end

  // read mux: latch for outputs, pin for inputs
  always @* begin
    rd_val = 32'h00000000;
    if (!addr_ok) begin
      rd_val = 32'h00000000;
    end else if (idx == `PORT_A_DATA_IDX) begin
      rd_val[AW-1:0] = (keypad_port_latch & keypad_port_direction)
        | (a_pin & ~keypad_port_direction);
    end else if (idx == `PORT_B_DATA_IDX) begin
      rd_val[BW-1:0] = (analog_port_latch & analog_port_direction & ~sel_mask)
        | (b_pin & ~(analog_port_direction & ~sel_mask));
    end else if (idx == `PORT_C_DATA_IDX) begin
      rd_val[CW-1:0] = (plain_port_latch & plain_port_direction)
        | (c_pin & ~plain_port_direction);
    end else if (idx == `PORT_A_DIRECTION_IDX) begin
      rd_val[AW-1:0] = keypad_port_direction;
    end else if (idx == `PORT_B_DIRECTION_IDX) begin
      rd_val[BW-1:0] = analog_port_direction;
    end else if (idx == `PORT_C_DIRECTION_IDX) begin
      rd_val[CW-1:0] = plain_port_direction;
    end else if (idx == `PORT_A_PULLUP_ENABLE_IDX) begin
      rd_val[AW-1:0] = keypad_port_pullup_en;
    end else if (idx == `PORT_C_PULLUP_ENABLE_IDX) begin
      rd_val[CW-1:0] = plain_port_pullup_en;
    end else if (idx == `ANALOG_SELECT_IDX) begin
      rd_val[7:0] = analog_select;
    end else if (idx == `KEYPAD_IRQ_ENABLE_IDX) begin
      rd_val[7:0] = keypad_irq_enable;
    end
  end

  // bus handshake and control registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      wr_pend <= 1'b0;
      wr_idx <= 4'h0;
      keypad_port_direction <= `DIRECTION_RESET;
      analog_port_direction <= `DIRECTION_RESET;
      plain_port_direction <= {CW{1'b0}};
      keypad_port_pullup_en <= `PULLUP_RESET;
      plain_port_pullup_en <= {CW{1'b0}};
      analog_select <= `ANALOG_SELECT_RESET;
      keypad_irq_enable <= `KEYPAD_IRQ_RESET;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= take && hwrite && addr_ok;
      if (take) begin
        wr_idx <= idx;
      end
      if (take && !hwrite) begin
        hrdata <= rd_val;
      end
      if (wr_pend) begin
        if (wr_idx == `PORT_A_DIRECTION_IDX) begin
          keypad_port_direction <= hwdata[AW-1:0];
        end else if (wr_idx == `PORT_B_DIRECTION_IDX) begin
          analog_port_direction <= hwdata[BW-1:0];
        end else if (wr_idx == `PORT_C_DIRECTION_IDX) begin
          plain_port_direction <= hwdata[CW-1:0];
        end else if (wr_idx == `PORT_A_PULLUP_ENABLE_IDX) begin
          keypad_port_pullup_en <= hwdata[AW-1:0];
        end else if (wr_idx == `PORT_C_PULLUP_ENABLE_IDX) begin
          plain_port_pullup_en <= hwdata[CW-1:0];
        end else if (wr_idx == `ANALOG_SELECT_IDX) begin
          analog_select <= hwdata[7:0];
        end else if (wr_idx == `KEYPAD_IRQ_ENABLE_IDX) begin
          keypad_irq_enable <= hwdata[7:0];
        end
      end
    end
  end

  // latches keep their contents across reset
  always @(posedge clk) begin
    if (wr_pend && wr_idx == `PORT_A_DATA_IDX) begin
      keypad_port_latch <= hwdata[AW-1:0];
    end
    if (wr_pend && wr_idx == `PORT_B_DATA_IDX) begin
      analog_port_latch <= hwdata[BW-1:0];
    end
    if (wr_pend && wr_idx == `PORT_C_DATA_IDX) begin
      plain_port_latch <= hwdata[CW-1:0];
    end
  end

  // pad controls, registered
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      keypad_out <= 8'h00;
      keypad_oe <= 8'h00;
      keypad_pullup <= 8'h00;
      keypad_irq_pin_en <= 8'h00;
      analog_out <= 8'h00;
      analog_oe <= 8'h00;
      analog_route <= 8'h00;
      plain_out <= 7'h00;
      plain_oe <= 7'h00;
      plain_pullup <= 7'h00;
    end else begin
      keypad_out <= keypad_port_latch;
      keypad_oe <= keypad_port_direction;
      keypad_pullup <= keypad_port_pullup_en & ~keypad_port_direction;
      keypad_irq_pin_en <= keypad_irq_enable;
      analog_out <= analog_port_latch;
      analog_oe <= analog_port_direction & ~sel_mask;
      analog_route <= sel_mask;
      plain_out <= plain_port_latch;
      plain_oe <= plain_port_direction;
      plain_pullup <= plain_port_pullup_en & ~plain_port_direction;
    end
  end

endmodule // three_port_parallel_io

// File: bench/three_port_parallel_io_props.sv
// assertions on the ports of the three-port i/o block
`timescale 1ns/1ns
module three_port_parallel_io_props (
  input wire clk, input wire rst, input wire hsel, input wire [31:0] haddr,
  input wire [1:0] htrans, input wire hwrite, input wire [31:0] hwdata, input wire hready,
  input wire hresp, input wire [7:0] keypad_oe, input wire [7:0] keypad_pullup,
  input wire [7:0] analog_oe, input wire [7:0] analog_route,
  input wire [6:0] plain_oe, input wire [6:0] plain_pullup
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire wr = hsel && hready && htrans[1] && hwrite;
  reset_inputs_a: assert property ($fell(rst) |-> !(keypad_oe | analog_oe) && !plain_oe)
    else $error("outputs enabled after reset");
  keypad_dir_a: assert property (wr && haddr == 32'h10 |-> ##3 keypad_oe == $past(hwdata[7:0], 2))
    else $error("keypad enable not written");
  plain_dir_a: assert property (wr && haddr == 32'h18 |-> ##3 plain_oe == $past(hwdata[6:0], 2))
    else $error("plain enable not written");
  pullup_set_a: assert property (wr && haddr == 32'h34 |->
    ##3 keypad_pullup == ($past(hwdata[7:0], 2) & ~keypad_oe)) else $error("keypad pullup wrong");
  keypad_pull_a: assert property ((keypad_pullup & keypad_oe) == 8'h00)
    else $error("keypad pullup on output");
  plain_pull_a: assert property ((plain_pullup & plain_oe) == 7'h00)
    else $error("plain pullup on output");
  route_input_a: assert property ((analog_route & analog_oe) == 8'h00)
    else $error("routed pin driven");
  route_single_a: assert property ($onehot0(analog_route))
    else $error("several pins routed");
  bus_okay_a: assert property (!hresp) else $error("error response");
endmodule // three_port_parallel_io_props
bind three_port_parallel_io three_port_parallel_io_props chk (.clk(clk), .rst(rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hresp(hresp), .keypad_oe(keypad_oe), .keypad_pullup(keypad_pullup), .analog_oe(analog_oe),
  .analog_route(analog_route), .plain_oe(plain_oe), .plain_pullup(plain_pullup));

// File: bench/pin_pad.sv
// board pins: driver, external source, pullup or floating
`timescale 1ns/1ns
module pin_pad #(parameter int W = 8) (
  input wire clk, // system clock
  input wire [W-1:0] out, oe, pu, ext, ext_en, // pad controls and outside source
  output logic [W-1:0] lvl // pin level
);
  logic [W-1:0] last = '0;
  always_comb
    for (int i = 0; i < W; i++)
      lvl[i] = oe[i] ? out[i] : ext_en[i] ? ext[i] : pu[i] ? 1'b1 : ~last[i];
  always @(posedge clk) last <= lvl;
endmodule // pin_pad

// File: bench/three_port_parallel_io_bench.sv
// self-checking bench of the three-port i/o block
`timescale 1ns/1ns
module three_port_parallel_io_bench;
  logic clk = 0, rst = 1, hsel = 0, hwrite = 0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = '0, hwdata = '0, r;
  logic [7:0] ken = 8'hFF, ben = 8'hFF;
  logic [6:0] cen = 7'h7F;
  logic [31:0] zr [8] = '{32'h10, 32'h14, 32'h18, 32'h34, 32'h38, 32'h24, 32'h28, 32'h3C};
  int failures = 0, tests_run = 0;
  wire hreadyout, hresp;
  wire [31:0] hrdata;
  wire [7:0] ko, koe, kpu, kirq, kin, ao, aoe, aroute, ain;
  wire [6:0] co, coe, cpu, cin;
  three_port_parallel_io dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .keypad_inputs(kin),
    .keypad_out(ko), .keypad_oe(koe), .keypad_pullup(kpu), .keypad_irq_pin_en(kirq),
    .analog_channel_inputs(ain), .analog_out(ao), .analog_oe(aoe), .analog_route(aroute),
    .plain_inputs(cin), .plain_out(co), .plain_oe(coe), .plain_pullup(cpu));
  pin_pad #(8) pa (.clk(clk), .out(ko), .oe(koe), .pu(kpu), .ext(8'h5A), .ext_en(ken), .lvl(kin));
  pin_pad #(8) pb (.clk(clk), .out(ao), .oe(aoe), .pu(8'h00), .ext(8'hC3), .ext_en(ben),
    .lvl(ain));
  pin_pad #(7) pc (.clk(clk), .out(co), .oe(coe), .pu(cpu), .ext(7'h2B), .ext_en(cen),
    .lvl(cin));
  initial forever #4 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(r, exp);
  endtask
  task automatic settle;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    end_sim;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (zr[i]) rd(zr[i], 32'h0);
    rd(32'h0, 32'h5A);
    rd(32'h4, 32'hC3);
    rd(32'h8, 32'h2B);
    bus(1'b1, 32'h0, 32'hF0);
    bus(1'b1, 32'h4, 32'h0F);
    bus(1'b1, 32'h8, 32'hFF);
    rd(32'h0, 32'h5A);
    bus(1'b1, 32'h10, 32'hFF);
    bus(1'b1, 32'h14, 32'hFF);
    bus(1'b1, 32'h18, 32'hFF);
    rd(32'h18, 32'h7F);
    settle;
    chk({24'h0, koe}, 32'hFF);
    chk({24'h0, ko}, 32'hF0);
    chk({24'h0, ao}, 32'h0F);
    chk({25'h0, co}, 32'h7F);
    rd(32'h0, 32'hF0);
    rd(32'h8, 32'h7F);
    bus(1'b1, 32'h24, 32'h0B);
    settle;
    chk({24'h0, aroute}, 32'h08);
    chk({24'h0, aoe}, 32'hF7);
    rd(32'h4, 32'h07);
    bus(1'b1, 32'h28, 32'hA5);
    settle;
    chk({24'h0, kirq}, 32'hA5);
    ken <= 8'h00;
    bus(1'b1, 32'h10, 32'h0F);
    bus(1'b1, 32'h34, 32'hFF);
    settle;
    chk({24'h0, kpu}, 32'hF0);
    rd(32'h0, 32'hF0);
    bus(1'b1, 32'h18, 32'h00);
    bus(1'b1, 32'h38, 32'hFF);
    settle;
    chk({25'h0, cpu}, 32'h7F);
    rd(32'h8, 32'h2B);
    cen <= 7'h00;
    settle;
    rd(32'h8, 32'h7F);
    chk({31'h0, hresp}, 32'h0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(32'h10, 32'h0);
    bus(1'b1, 32'h10, 32'hFF);
    settle;
    rd(32'h0, 32'hF0);
    end_sim;
  end
endmodule // three_port_parallel_io_bench
